// *** ipp_alu.v ***
`timescale 1ns/1ps
`default_nettype none
`include "ipp_map.vh"

module ipp_alu (
	input wire [3:0] op_i,
	input wire [7:0] acc_i,
	input wire [7:0] operand_i,
	output reg [7:0] result_o,
	output reg carry_o
);

	// Nine-bit sum keeps the carry out of the add and the borrow of subtract
	reg [8:0] wide;

	// Pure combinational eight-bit datapath
	always @* begin
		wide = {1'b0, acc_i};
		result_o = acc_i;
		carry_o = 1'b0;
		case (op_i)
			`IPP_ALU_MOV: begin
				result_o = operand_i;
			end
			`IPP_ALU_ADD: begin
				wide = {1'b0, acc_i} + {1'b0, operand_i};
				result_o = wide[7:0];
				carry_o = wide[8];
			end
			`IPP_ALU_SUB: begin
				// Carry set means no borrow
				wide = {1'b0, acc_i} - {1'b0, operand_i};
				result_o = wide[7:0];
				carry_o = ~wide[8];
			end
			`IPP_ALU_AND: begin
				result_o = acc_i & operand_i;
			end
			`IPP_ALU_OR: begin
				result_o = acc_i | operand_i;
			end
			`IPP_ALU_XOR: begin
				result_o = acc_i ^ operand_i;
			end
			`IPP_ALU_CPL: begin
				result_o = ~acc_i;
			end
			`IPP_ALU_RR: begin
				result_o = {acc_i[0], acc_i[7:1]};
				carry_o = acc_i[0];
			end
			`IPP_ALU_RL: begin
				result_o = {acc_i[6:0], acc_i[7]};
				carry_o = acc_i[7];
			end
			`IPP_ALU_INC: begin
				result_o = acc_i + `IPP_BYTE_ONE;
			end
			`IPP_ALU_DEC: begin
				result_o = acc_i - `IPP_BYTE_ONE;
			end
			default: begin
				// Undefined op leaves the accumulator as it is
				result_o = acc_i;
			end
		endcase
	end

endmodule
`default_nettype wire

// *** ipp_core.v ***
// Contract
// (RQ1) One main clock from four sources
// (RQ2) Four non-overlapping phases form one cycle
// (RQ3) Fetch phase increments counter, fetches next
// (RQ4) Later three phases decode and execute
// (RQ5) Fetch overlaps execute, one per cycle
// (RQ6) Counter-loading instructions take two cycles
// (RQ7) Branch: get target, then branch there
// (RQ8) Eight-bit ALU through the accumulator
// (RQ9) Taken skip discards prefetch, dummy cycle
// (RQ10) Branch flushes sequential prefetched word
`timescale 1ns/1ps
`default_nettype none
`include "ipp_map.vh"

module ipp_core (
	input wire clock_i,
	input wire resetn_i,
	input wire [1:0] osc_select_i,
	input wire [15:0] instr_i,
	output reg [3:0] phase_o,
	output reg fetch_phase_o,
	output reg [11:0] mem_addr_o,
	output reg [7:0] acc_o,
	output reg zero_o,
	output reg carry_o,
	output reg retire_o,
	output reg flush_o
);

	// Phase codes as machine states
	localparam PH_FETCH = `IPP_PH_FETCH;
	localparam PH_DECODE = `IPP_PH_DECODE;
	localparam PH_ALU = `IPP_PH_ALU;
	localparam PH_COMMIT = `IPP_PH_COMMIT;

	reg [2:0] div_count; // Main clock divider
	reg [2:0] div_limit; // Terminal count of selected source
	reg tick; // One main system clock period
	reg [1:0] phase; // Current phase
	reg [1:0] next_phase;
	reg [11:0] pc; // Address of the word after the one in fetch
	reg [15:0] fetch_ir; // Word captured in the fetch phase
	reg fetch_valid; // Captured word may execute
	reg [15:0] exec_ir; // Word in decode and execute
	reg exec_valid; // Low during a dummy cycle
	reg [3:0] dec_class; // Latched class from decode phase
	reg [11:0] dec_target; // Latched branch target
	reg [7:0] alu_hold; // ALU result latched in its phase
	reg carry_hold;
	reg redirect; // Counter loaded at end of this cycle
	reg skip_taken; // Next word must be dropped
	reg [11:0] next_base; // Fetch address for next cycle
	wire [7:0] alu_result;
	wire alu_carry;

	// (RQ1) Source select picks divider
	always @* begin
		case (osc_select_i)
			`IPP_OSC_FAST_XTAL: begin
				div_limit = `IPP_DIV_FAST_XTAL;
			end
			`IPP_OSC_SLOW_XTAL: begin
				div_limit = `IPP_DIV_SLOW_XTAL;
			end
			`IPP_OSC_FAST_RC: begin
				div_limit = `IPP_DIV_FAST_RC;
			end
			default: begin
				div_limit = `IPP_DIV_SLOW_RC;
			end
		endcase
		// Compare by >= so a smaller limit after a switch cannot overshoot
		tick = (div_count >= div_limit);
	end

	// (RQ1) Main clock enable divider
	always @(posedge clock_i) begin
		if (!resetn_i) begin
			div_count <= `IPP_DIV_ZERO;
		end else if (tick) begin
			div_count <= `IPP_DIV_ZERO;
		end else begin
			div_count <= div_count + `IPP_DIV_ONE;
		end
	end

	// Phase successor wraps after commit
	always @* begin
		case (phase)
			PH_FETCH: begin
				next_phase = PH_DECODE;
			end
			PH_DECODE: begin
				next_phase = PH_ALU;
			end
			PH_ALU: begin
				next_phase = PH_COMMIT;
			end
			PH_COMMIT: begin
				next_phase = PH_FETCH;
			end
			default: begin
				next_phase = PH_FETCH;
			end
		endcase
	end

	// (RQ2) Four phases, exactly one hot
	always @(posedge clock_i) begin
		if (!resetn_i) begin
			phase <= PH_FETCH;
			phase_o <= `IPP_PH_ONEHOT_BASE;
			fetch_phase_o <= 1'b1;
		end else if (tick) begin
			phase <= next_phase;
			phase_o <= `IPP_PH_ONEHOT_BASE << next_phase;
			fetch_phase_o <= (next_phase == PH_FETCH);
		end
	end

	// (RQ8) Eight-bit ALU on accumulator
	ipp_alu u_alu (
		.op_i(exec_ir[`IPP_AOP_HI:`IPP_AOP_LO]),
		.acc_i(acc_o),
		.operand_i(exec_ir[`IPP_IMM_HI:`IPP_IMM_LO]),
		.result_o(alu_result),
		.carry_o(alu_carry)
	);

	// Branch and skip decisions for the end of this cycle
	always @* begin
		// (RQ6) Jump and call load the counter
		redirect = exec_valid &&
			((dec_class == `IPP_OPC_JMP) || (dec_class == `IPP_OPC_CALL));
		// (RQ9) Skip on zero or non-zero
		skip_taken = exec_valid &&
			(((dec_class == `IPP_OPC_SZA) && zero_o) ||
			((dec_class == `IPP_OPC_SNZA) && !zero_o));
		// (RQ7) Target fetched in following cycle
		next_base = redirect ? dec_target : pc;
	end

	// (RQ3) Fetch address and counter step
	always @(posedge clock_i) begin
		if (!resetn_i) begin
			mem_addr_o <= `IPP_RESET_VECTOR;
			pc <= `IPP_RESET_VECTOR + `IPP_PC_STEP;
		end else if (tick && (phase == PH_COMMIT)) begin
			// Counter moves as the next fetch phase begins
			mem_addr_o <= next_base;
			pc <= next_base + `IPP_PC_STEP;
		end
	end

	// (RQ5) Capture word while previous executes
	always @(posedge clock_i) begin
		if (!resetn_i) begin
			fetch_ir <= `IPP_WORD_RESET;
			fetch_valid <= 1'b0;
		end else if (tick && (phase == PH_FETCH)) begin
			fetch_ir <= instr_i;
			fetch_valid <= 1'b1;
		end
	end

	// Hand the prefetched word to execute at cycle boundary
	always @(posedge clock_i) begin
		if (!resetn_i) begin
			exec_ir <= `IPP_WORD_RESET;
			exec_valid <= 1'b0;
			flush_o <= 1'b0;
		end else if (tick && (phase == PH_COMMIT)) begin
			exec_ir <= fetch_ir;
			// (RQ10) Drop sequential word on branch
			// (RQ9) Dropped word becomes dummy cycle
			exec_valid <= fetch_valid && !redirect && !skip_taken;
			flush_o <= fetch_valid && (redirect || skip_taken);
		end else begin
			flush_o <= 1'b0;
		end
	end

	// (RQ4) Decode, ALU, commit phases
	always @(posedge clock_i) begin
		if (!resetn_i) begin
			dec_class <= `IPP_OPC_NOP;
			dec_target <= `IPP_RESET_VECTOR;
			alu_hold <= `IPP_ACC_RESET;
			carry_hold <= 1'b0;
			acc_o <= `IPP_ACC_RESET;
			zero_o <= 1'b1;
			carry_o <= 1'b0;
			retire_o <= 1'b0;
		end else begin
			retire_o <= 1'b0;
			if (tick) begin
				case (phase)
					PH_DECODE: begin
						// Class and target latched once per cycle
						dec_class <= exec_ir[`IPP_OPC_HI:`IPP_OPC_LO];
						dec_target <= exec_ir[`IPP_TGT_HI:`IPP_TGT_LO];
					end
					PH_ALU: begin
						// Result held so commit sees a stable value
						alu_hold <= alu_result;
						carry_hold <= alu_carry;
					end
					PH_COMMIT: begin
						// Dummy cycles write nothing and retire nothing
						if (exec_valid && (dec_class == `IPP_OPC_ALU)) begin
							acc_o <= alu_hold;
							zero_o <= (alu_hold == `IPP_ACC_RESET);
							carry_o <= carry_hold;
						end
						retire_o <= exec_valid;
					end
					default: begin
						// Fetch phase: execute side idle
						dec_class <= dec_class;
					end
				endcase
			end
		end
	end

endmodule
`default_nettype wire

// *** ipp_core_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module ipp_core_props (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [3:0] phase_o,
	input wire logic fetch_phase_o,
	input wire logic [11:0] mem_addr_o,
	input wire logic [7:0] acc_o,
	input wire logic retire_o,
	input wire logic flush_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	phase_hot_a: assert property ($onehot(phase_o))
		else $error("phase not one-hot");
	phase_turn_a: assert property ($changed(phase_o) |->
		phase_o == {$past(phase_o[2:0]), $past(phase_o[3])}) else $error("phase order");
	fetch_flag_a: assert property (fetch_phase_o == phase_o[0])
		else $error("fetch flag");
	addr_edge_a: assert property ($changed(mem_addr_o) |->
		phase_o[0] && $past(phase_o[3])) else $error("addr moved off fetch");
	addr_step_a: assert property ($changed(mem_addr_o) && !flush_o |->
		mem_addr_o == $past(mem_addr_o) + 12'h001) else $error("addr step");
	retire_fetch_a: assert property (retire_o |-> phase_o[0])
		else $error("retire off fetch");
	retire_pulse_a: assert property (retire_o |=> !retire_o)
		else $error("retire too long");
	flush_ret_a: assert property (flush_o |-> retire_o)
		else $error("flush without retire");
	dummy_gap_a: assert property (flush_o |=> !retire_o [*7])
		else $error("no dummy cycle");
	acc_commit_a: assert property ($changed(acc_o) |-> retire_o)
		else $error("acc off commit");
	// Main paths reached
	cover property (flush_o);
	cover property (retire_o && acc_o == 8'h10);
	cover property (phase_o[3] [*8]);
	cover property (flush_o && mem_addr_o == 12'h00d);
endmodule
bind ipp_core ipp_core_props chk_u (
	.clock_i(clock_i),
	.resetn_i(resetn_i),
	.phase_o(phase_o),
	.fetch_phase_o(fetch_phase_o),
	.mem_addr_o(mem_addr_o),
	.acc_o(acc_o),
	.retire_o(retire_o),
	.flush_o(flush_o)
);
`default_nettype wire

// *** ipp_map.vh ***
`ifndef IPP_MAP_VH
`define IPP_MAP_VH

// Oscillator source select codes
`define IPP_OSC_FAST_XTAL 2'h0
`define IPP_OSC_SLOW_XTAL 2'h1
`define IPP_OSC_FAST_RC 2'h2
`define IPP_OSC_SLOW_RC 2'h3

// Divider terminal counts (main clock tick every count+1 cycles)
`define IPP_DIV_FAST_XTAL 3'h0
`define IPP_DIV_FAST_RC 3'h1
`define IPP_DIV_SLOW_XTAL 3'h3
`define IPP_DIV_SLOW_RC 3'h7
`define IPP_DIV_ZERO 3'h0
`define IPP_DIV_ONE 3'h1

// Phase codes within one instruction cycle
`define IPP_PH_FETCH 2'h0
`define IPP_PH_DECODE 2'h1
`define IPP_PH_ALU 2'h2
`define IPP_PH_COMMIT 2'h3
`define IPP_PH_ONE 2'h1
`define IPP_PH_ONEHOT_BASE 4'h1

// Instruction word fields
`define IPP_OPC_HI 15
`define IPP_OPC_LO 12
`define IPP_AOP_HI 11
`define IPP_AOP_LO 8
`define IPP_IMM_HI 7
`define IPP_IMM_LO 0
`define IPP_TGT_HI 11
`define IPP_TGT_LO 0

// Instruction classes
`define IPP_OPC_NOP 4'h0
`define IPP_OPC_ALU 4'h1
`define IPP_OPC_JMP 4'h2
`define IPP_OPC_CALL 4'h3
`define IPP_OPC_SZA 4'h4
`define IPP_OPC_SNZA 4'h5

// ALU operations
`define IPP_ALU_MOV 4'h0
`define IPP_ALU_ADD 4'h1
`define IPP_ALU_SUB 4'h2
`define IPP_ALU_AND 4'h3
`define IPP_ALU_OR 4'h4
`define IPP_ALU_XOR 4'h5
`define IPP_ALU_CPL 4'h6
`define IPP_ALU_RR 4'h7
`define IPP_ALU_RL 4'h8
`define IPP_ALU_INC 4'h9
`define IPP_ALU_DEC 4'ha

// Reset values
`define IPP_RESET_VECTOR 12'h000
`define IPP_PC_STEP 12'h001
`define IPP_ACC_RESET 8'h00
`define IPP_WORD_RESET 16'h0000
`define IPP_BYTE_ONE 8'h01

`endif

// *** ipp_prog_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// Program store; unused words read as no-op
module ipp_prog_mem (
	input wire logic bank_i,
	input wire logic [11:0] addr_i,
	output logic [15:0] word_o
);
	// Two banks of sixteen words, picked by the bench as it asserts reset
	logic [15:0] words [0:31];
	assign word_o = words[{bank_i, addr_i[3:0]}];
	initial begin
		for (int i = 0; i < 32; i++) begin
			words[i] = 16'h0000;
		end
		words[0] = 16'h1000;
		words[1] = 16'h4000;
		words[2] = 16'h1055;
		words[3] = 16'h10f0;
		words[4] = 16'h1120;
		words[5] = 16'h2008;
		words[6] = 16'h1077;
		words[8] = 16'h15ff;
		words[9] = 16'h5000;
		words[10] = 16'h1033;
		words[11] = 16'h200b;
		// Bank one: every ALU op but XOR, a call and an undefined class
		words[16] = 16'h1001;
		words[17] = 16'h1a00;
		words[18] = 16'h1900;
		words[19] = 16'h1117;
		words[20] = 16'h1208;
		words[21] = 16'h130f;
		words[22] = 16'h1449;
		words[23] = 16'h1600;
		words[24] = 16'h1800;
		words[25] = 16'h1700;
		words[26] = 16'h300d;
		words[27] = 16'h1000;
		words[29] = 16'h6000;
		words[31] = 16'h200f;
	end
endmodule
`default_nettype wire

// *** tb_instruction_phase_pipeline.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_instruction_phase_pipeline;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [1:0] osc_select_i = 2'h0;
	logic bank = 1'b0;
	logic [15:0] word;
	logic [3:0] phase_o;
	logic fetch_phase_o;
	logic [11:0] mem_addr_o;
	logic [7:0] acc_o;
	logic zero_o;
	logic carry_o;
	logic retire_o;
	logic flush_o;
	int err_total = 0;
	int n_tests = 0;
	ipp_prog_mem pm_u (.bank_i(bank), .addr_i(mem_addr_o), .word_o(word));
	ipp_core dut_u (.clock_i(clock_i), .resetn_i(resetn_i),
		.osc_select_i(osc_select_i), .instr_i(word), .phase_o(phase_o),
		.fetch_phase_o(fetch_phase_o), .mem_addr_o(mem_addr_o), .acc_o(acc_o),
		.zero_o(zero_o), .carry_o(carry_o), .retire_o(retire_o), .flush_o(flush_o));
	initial begin
		forever #2.5 clock_i = ~clock_i;
	end
	task close_out;
		if (err_total == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Reset held three clocks under a chosen source
	task boot(input logic [1:0] s, input logic b);
		@(posedge clock_i);
		resetn_i <= 1'b0;
		osc_select_i <= s;
		bank <= b;
		repeat (2) @(posedge clock_i);
		#1;
		chk({4'h0, mem_addr_o}, 16'h0000);
		chk({12'h000, phase_o}, 16'h0001);
		@(posedge clock_i);
		resetn_i <= 1'b1;
	endtask
	// Wait for next retire, bounded, then judge it
	task step(input logic [7:0] ea, input logic ef, input logic [11:0] ad, input int cyc);
		int n;
		n = 0;
		while (n < 100) begin
			@(posedge clock_i);
			#1;
			n++;
			if (retire_o === 1'b1) break;
		end
		if (retire_o !== 1'b1) begin
			// A retire that never comes ends the run as a failure
			chk({15'h0000, retire_o}, 16'h0001);
			close_out();
		end else begin
			chk({8'h00, acc_o}, {8'h00, ea});
			chk({15'h0000, flush_o}, {15'h0000, ef});
			chk({4'h0, mem_addr_o}, {4'h0, ad});
			if (cyc > 0) chk(n[15:0], cyc[15:0]);
		end
	endtask
	// Whole program: skips, jump, dropped prefetches
	task run_prog(input logic [1:0] s);
		int d;
		d = (s == 2'h0) ? 1 : (s == 2'h1) ? 4 : (s == 2'h2) ? 2 : 8;
		boot(s, 1'b0);
		// First word retires two instruction cycles after release
		step(8'h00, 1'b0, 12'h002, 8 * d);
		chk({15'h0000, zero_o}, 16'h0001);
		step(8'h00, 1'b1, 12'h003, 4 * d);
		step(8'hf0, 1'b0, 12'h005, 8 * d);
		step(8'h10, 1'b0, 12'h006, 4 * d);
		chk({15'h0000, carry_o}, 16'h0001);
		step(8'h10, 1'b1, 12'h008, 4 * d);
		step(8'hef, 1'b0, 12'h00a, 8 * d);
		step(8'hef, 1'b1, 12'h00b, 4 * d);
		chk({15'h0000, zero_o}, 16'h0000);
	endtask
	// Second bank on the fast RC source: ALU ops, call, undefined class
	task run_ops;
		boot(2'h2, 1'b1);
		step(8'h01, 1'b0, 12'h002, 16);
		step(8'h00, 1'b0, 12'h003, 8);
		chk({14'h0000, zero_o, carry_o}, 16'h0002);
		step(8'h01, 1'b0, 12'h004, 8);
		chk({15'h0000, zero_o}, 16'h0000);
		step(8'h18, 1'b0, 12'h005, 8);
		step(8'h10, 1'b0, 12'h006, 8);
		chk({15'h0000, carry_o}, 16'h0001);
		step(8'h00, 1'b0, 12'h007, 8);
		chk({14'h0000, zero_o, carry_o}, 16'h0002);
		step(8'h49, 1'b0, 12'h008, 8);
		step(8'hb6, 1'b0, 12'h009, 8);
		step(8'h6d, 1'b0, 12'h00a, 8);
		chk({15'h0000, carry_o}, 16'h0001);
		step(8'hb6, 1'b0, 12'h00b, 8);
		step(8'hb6, 1'b1, 12'h00d, 8);
		// Dropped word would clear the accumulator if it ran
		step(8'hb6, 1'b0, 12'h00f, 16);
		step(8'hb6, 1'b0, 12'h010, 8);
		step(8'hb6, 1'b1, 12'h00f, 8);
	endtask
	initial begin
		for (int s = 0; s < 4; s++) begin
			run_prog(s[1:0]);
		end
		run_ops();
		close_out();
	end
endmodule
`default_nettype wire
